/* hw/rdx_defs.vh */
// Constants for the receive data link extractor
// Function
// - Five-bit slot field selects the received slot
// - T1 channel one maps to slot value zero
// - Even select takes bits from even frames
// - Odd select takes bits from odd frames
// - Frames count 0-15 E1, from 1 T1
// - Both selects zero means no slot bits are extracted
// - Mask ones pick the slot bits extracted
// - Mask bit 7 is first received bit
// - Three independent links feed three HDLC receivers
// - Link one T1 enable takes framer link positions
`ifndef RDX_DEFS_VH
`define RDX_DEFS_VH

// Register indices; byte address is four times the index
`define RDX_IDX_LINK1_CTRL   6'h28
`define RDX_IDX_LINK1_MASK   6'h29
`define RDX_IDX_LINK2_CTRL   6'h2A
`define RDX_IDX_LINK2_MASK   6'h2B
`define RDX_IDX_LINK3_CTRL   6'h2C
`define RDX_IDX_LINK3_MASK   6'h2D
`define RDX_IDX_MODE         6'h2E
`define RDX_IDX_FRAME_STAT   6'h2F
`define RDX_IDX_LINK1_COUNT  6'h3C
`define RDX_IDX_LINK2_COUNT  6'h3D
`define RDX_IDX_LINK3_COUNT  6'h3E

// Reset values
`define RDX_RST_LINK1_CTRL   8'h20
`define RDX_RST_CTRL         8'h00
`define RDX_RST_MASK         8'h00
`define RDX_RST_MODE         8'h00
`define RDX_RST_COUNT        8'h00
`define RDX_RST_RDATA        32'h00000000

// Word index within the byte address
`define RDX_ADR_IDX_HI       7
`define RDX_ADR_IDX_LO       2

// Frame number bit that gives the parity
`define RDX_FRAME_PARITY     0

// Control register fields
`define RDX_CTRL_EVEN        7
`define RDX_CTRL_ODD         6
`define RDX_CTRL_FDL_EN      5
`define RDX_CTRL_SLOT_HI     4
`define RDX_CTRL_SLOT_LO     0
`define RDX_MODE_E1          0

// Frame numbering bases
`define RDX_E1_FIRST_FRAME   5'h00
`define RDX_T1_FIRST_FRAME   5'h01
`define RDX_T1_CHAN_OFFSET   5'h01

// Bit position of the first received bit in the mask
`define RDX_MASK_TOP         3'h7

`endif

/* hw/rdx_frame_cnt.v */
// Frame number tracker within the receive multiframe
`default_nettype none
`include "rdx_defs.vh"

module rdx_frame_cnt (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       ce,
  input  wire       e1_mode,
  input  wire       bit_en,
  input  wire       fr_start,
  input  wire       mf_start,
  output reg  [4:0] frame_num,
  output wire [4:0] frame_num_q
);

  reg [4:0] num_q;
  reg [4:0] num_d;

  assign frame_num_q = num_q;

  // Number valid for the bit now on the stream
  always @* begin
    num_d = num_q;
    if (bit_en && fr_start) begin
      if (mf_start) begin
        num_d = e1_mode ? `RDX_E1_FIRST_FRAME : `RDX_T1_FIRST_FRAME;
      end else begin
        num_d = num_q + 5'h01;
      end
    end
    frame_num = num_d;
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      num_q <= `RDX_E1_FIRST_FRAME;
    end else if (ce) begin
      num_q <= num_d;
    end
  end

endmodule
`default_nettype wire

/* hw/rdx_link_sel.v */
// One data link extraction channel
`default_nettype none
`include "rdx_defs.vh"

module rdx_link_sel #(
  parameter FDL_CAPABLE = 0
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       ce,
  input  wire       e1_mode,
  input  wire [7:0] ctrl,
  input  wire [7:0] bit_mask,
  input  wire       bit_en,
  input  wire       rx_data,
  input  wire       rx_fbit,
  input  wire [4:0] rx_slot,
  input  wire [2:0] rx_bit_num,
  input  wire       frame_odd,
  input  wire       fdl_pos,
  output reg        link_bit_q,
  output reg        link_valid_q
);

  wire       even_sel = ctrl[`RDX_CTRL_EVEN];
  wire       odd_sel  = ctrl[`RDX_CTRL_ODD];
  wire [4:0] slot_num = ctrl[`RDX_CTRL_SLOT_HI:`RDX_CTRL_SLOT_LO];
  wire [4:0] slot_cmp;
  wire       frame_ok;
  wire       slot_hit;
  wire       mask_hit;
  wire       fdl_hit;
  wire       take;

  // T1 channels arrive numbered from one
  assign slot_cmp = e1_mode ? rx_slot : rx_slot - `RDX_T1_CHAN_OFFSET;
  assign frame_ok = frame_odd ? odd_sel : even_sel;
  assign slot_hit = !rx_fbit && (slot_cmp == slot_num);
  assign mask_hit = bit_mask[`RDX_MASK_TOP - rx_bit_num];
  // Framer link positions only in T1; selects assumed cleared by software
  assign fdl_hit  = (FDL_CAPABLE != 0) && !e1_mode && ctrl[`RDX_CTRL_FDL_EN] && fdl_pos;
  assign take     = bit_en && ((frame_ok && slot_hit && mask_hit) || fdl_hit);

  always @(posedge clk) begin
    if (!rst_n) begin
      link_bit_q   <= 1'b0;
      link_valid_q <= 1'b0;
    end else if (ce) begin
      link_valid_q <= take;
      if (take) begin
        link_bit_q <= rx_data;
      end
    end
  end

endmodule
`default_nettype wire

/* hw/rdx_top.v */
// Receive data link extractor: Wishbone registers and three link channels
`default_nettype none
`include "rdx_defs.vh"

module rdx_top (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  // Wishbone classic slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Framer receive stream
  input  wire        rx_bit_en,
  input  wire        rx_data,
  input  wire        rx_fr_start,
  input  wire        rx_mf_start,
  input  wire        rx_fbit,
  input  wire [4:0]  rx_slot,
  input  wire [2:0]  rx_bit_num,
  input  wire        rx_fdl_pos,
  // HDLC receiver feeds
  output wire        link1_bit,
  output wire        link1_valid,
  output wire        link2_bit,
  output wire        link2_valid,
  output wire        link3_bit,
  output wire        link3_valid,
  output wire        e1_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  reg  [7:0] link1_control_q;
  reg  [7:0] link1_bit_mask_q;
  reg  [7:0] link2_control_q;
  reg  [7:0] link2_bit_mask_q;
  reg  [7:0] link3_control_q;
  reg  [7:0] link3_bit_mask_q;
  reg  [7:0] mode_q;
  reg  [7:0] link1_count_q;
  reg  [7:0] link2_count_q;
  reg  [7:0] link3_count_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire [5:0] idx;
  wire       req;
  wire       wr_stb;
  wire       rd_stb;
  wire       lane0_wr;
  reg  [7:0] rd_byte;
  reg        ack_d;

  assign idx      = wb_adr_i[`RDX_ADR_IDX_HI:`RDX_ADR_IDX_LO];
  assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_stb   = req && wb_we_i;
  assign rd_stb   = req && !wb_we_i;
  assign lane0_wr = wr_stb && wb_sel_i[0];

  always @* begin
    ack_d = req;
  end

  // One write strobe per writable register, low byte lane only
  reg        wr_link1_ctrl;
  reg        wr_link1_mask;
  reg        wr_link2_ctrl;
  reg        wr_link2_mask;
  reg        wr_link3_ctrl;
  reg        wr_link3_mask;
  reg        wr_mode;
  reg        wr_cnt1;
  reg        wr_cnt2;
  reg        wr_cnt3;

  always @* begin
    wr_link1_ctrl = 1'b0;
    wr_link1_mask = 1'b0;
    wr_link2_ctrl = 1'b0;
    wr_link2_mask = 1'b0;
    wr_link3_ctrl = 1'b0;
    wr_link3_mask = 1'b0;
    wr_mode       = 1'b0;
    wr_cnt1       = 1'b0;
    wr_cnt2       = 1'b0;
    wr_cnt3       = 1'b0;
    if (lane0_wr) begin
      case (idx)
        `RDX_IDX_LINK1_CTRL:  wr_link1_ctrl = 1'b1;
        `RDX_IDX_LINK1_MASK:  wr_link1_mask = 1'b1;
        `RDX_IDX_LINK2_CTRL:  wr_link2_ctrl = 1'b1;
        `RDX_IDX_LINK2_MASK:  wr_link2_mask = 1'b1;
        `RDX_IDX_LINK3_CTRL:  wr_link3_ctrl = 1'b1;
        `RDX_IDX_LINK3_MASK:  wr_link3_mask = 1'b1;
        `RDX_IDX_MODE:        wr_mode       = 1'b1;
        `RDX_IDX_LINK1_COUNT: wr_cnt1       = 1'b1;
        `RDX_IDX_LINK2_COUNT: wr_cnt2       = 1'b1;
        `RDX_IDX_LINK3_COUNT: wr_cnt3       = 1'b1;
        default:              wr_mode       = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  reg  [7:0] link1_control_d;
  reg  [7:0] link1_bit_mask_d;
  reg  [7:0] link2_control_d;
  reg  [7:0] link2_bit_mask_d;
  reg  [7:0] link3_control_d;
  reg  [7:0] link3_bit_mask_d;
  reg  [7:0] mode_d;

  always @* begin
    link1_control_d  = link1_control_q;
    link1_bit_mask_d = link1_bit_mask_q;
    link2_control_d  = link2_control_q;
    link2_bit_mask_d = link2_bit_mask_q;
    link3_control_d  = link3_control_q;
    link3_bit_mask_d = link3_bit_mask_q;
    mode_d           = mode_q;
    if (wr_link1_ctrl) begin
      link1_control_d = wb_dat_i[7:0];
    end
    if (wr_link1_mask) begin
      link1_bit_mask_d = wb_dat_i[7:0];
    end
    if (wr_link2_ctrl) begin
      link2_control_d = wb_dat_i[7:0];
    end
    if (wr_link2_mask) begin
      link2_bit_mask_d = wb_dat_i[7:0];
    end
    if (wr_link3_ctrl) begin
      link3_control_d = wb_dat_i[7:0];
    end
    if (wr_link3_mask) begin
      link3_bit_mask_d = wb_dat_i[7:0];
    end
    if (wr_mode) begin
      mode_d = wb_dat_i[7:0];
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      link1_control_q  <= `RDX_RST_LINK1_CTRL;
      link1_bit_mask_q <= `RDX_RST_MASK;
      link2_control_q  <= `RDX_RST_CTRL;
      link2_bit_mask_q <= `RDX_RST_MASK;
      link3_control_q  <= `RDX_RST_CTRL;
      link3_bit_mask_q <= `RDX_RST_MASK;
      mode_q           <= `RDX_RST_MODE;
    end else if (ce) begin
      link1_control_q  <= link1_control_d;
      link1_bit_mask_q <= link1_bit_mask_d;
      link2_control_q  <= link2_control_d;
      link2_bit_mask_q <= link2_bit_mask_d;
      link3_control_q  <= link3_control_d;
      link3_bit_mask_q <= link3_bit_mask_d;
      mode_q           <= mode_d;
    end
  end

  assign e1_mode = mode_q[`RDX_MODE_E1];

  ////////////////////////////////////////////////////////////////////////////
  // Frame numbering

  wire [4:0] frame_num;
  wire [4:0] frame_num_q;

  rdx_frame_cnt u_frame_cnt (
    .clk         (clk),
    .rst_n       (rst_n),
    .ce          (ce),
    .e1_mode     (e1_mode),
    .bit_en      (rx_bit_en),
    .fr_start    (rx_fr_start),
    .mf_start    (rx_mf_start),
    .frame_num   (frame_num),
    .frame_num_q (frame_num_q)
  );

  // Parity of the frame number as numbered per mode
  wire frame_odd = frame_num[`RDX_FRAME_PARITY];

  ////////////////////////////////////////////////////////////////////////////
  // Link channels, one per HDLC receiver

  rdx_link_sel #(
    .FDL_CAPABLE (1)
  ) u_link1 (
    .clk          (clk),
    .rst_n        (rst_n),
    .ce           (ce),
    .e1_mode      (e1_mode),
    .ctrl         (link1_control_q),
    .bit_mask     (link1_bit_mask_q),
    .bit_en       (rx_bit_en),
    .rx_data      (rx_data),
    .rx_fbit      (rx_fbit),
    .rx_slot      (rx_slot),
    .rx_bit_num   (rx_bit_num),
    .frame_odd    (frame_odd),
    .fdl_pos      (rx_fdl_pos),
    .link_bit_q   (link1_bit),
    .link_valid_q (link1_valid)
  );

  rdx_link_sel #(
    .FDL_CAPABLE (0)
  ) u_link2 (
    .clk          (clk),
    .rst_n        (rst_n),
    .ce           (ce),
    .e1_mode      (e1_mode),
    .ctrl         (link2_control_q),
    .bit_mask     (link2_bit_mask_q),
    .bit_en       (rx_bit_en),
    .rx_data      (rx_data),
    .rx_fbit      (rx_fbit),
    .rx_slot      (rx_slot),
    .rx_bit_num   (rx_bit_num),
    .frame_odd    (frame_odd),
    .fdl_pos      (rx_fdl_pos),
    .link_bit_q   (link2_bit),
    .link_valid_q (link2_valid)
  );

  rdx_link_sel #(
    .FDL_CAPABLE (0)
  ) u_link3 (
    .clk          (clk),
    .rst_n        (rst_n),
    .ce           (ce),
    .e1_mode      (e1_mode),
    .ctrl         (link3_control_q),
    .bit_mask     (link3_bit_mask_q),
    .bit_en       (rx_bit_en),
    .rx_data      (rx_data),
    .rx_fbit      (rx_fbit),
    .rx_slot      (rx_slot),
    .rx_bit_num   (rx_bit_num),
    .frame_odd    (frame_odd),
    .fdl_pos      (rx_fdl_pos),
    .link_bit_q   (link3_bit),
    .link_valid_q (link3_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Extracted bit counters; a clear with a delivered bit loads one

  reg  [7:0] link1_count_d;
  reg  [7:0] link2_count_d;
  reg  [7:0] link3_count_d;

  always @* begin
    link1_count_d = link1_count_q;
    if (link1_valid) begin
      link1_count_d = wr_cnt1 ? 8'h01 : link1_count_q + 8'h01;
    end else if (wr_cnt1) begin
      link1_count_d = `RDX_RST_COUNT;
    end
  end

  always @* begin
    link2_count_d = link2_count_q;
    if (link2_valid) begin
      link2_count_d = wr_cnt2 ? 8'h01 : link2_count_q + 8'h01;
    end else if (wr_cnt2) begin
      link2_count_d = `RDX_RST_COUNT;
    end
  end

  always @* begin
    link3_count_d = link3_count_q;
    if (link3_valid) begin
      link3_count_d = wr_cnt3 ? 8'h01 : link3_count_q + 8'h01;
    end else if (wr_cnt3) begin
      link3_count_d = `RDX_RST_COUNT;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      link1_count_q <= `RDX_RST_COUNT;
      link2_count_q <= `RDX_RST_COUNT;
      link3_count_q <= `RDX_RST_COUNT;
    end else if (ce) begin
      link1_count_q <= link1_count_d;
      link2_count_q <= link2_count_d;
      link3_count_q <= link3_count_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped words read zero

  always @* begin
    case (idx)
      `RDX_IDX_LINK1_CTRL:  rd_byte = link1_control_q;
      `RDX_IDX_LINK1_MASK:  rd_byte = link1_bit_mask_q;
      `RDX_IDX_LINK2_CTRL:  rd_byte = link2_control_q;
      `RDX_IDX_LINK2_MASK:  rd_byte = link2_bit_mask_q;
      `RDX_IDX_LINK3_CTRL:  rd_byte = link3_control_q;
      `RDX_IDX_LINK3_MASK:  rd_byte = link3_bit_mask_q;
      `RDX_IDX_MODE:        rd_byte = mode_q;
      `RDX_IDX_FRAME_STAT:  rd_byte = {3'h0, frame_num_q};
      `RDX_IDX_LINK1_COUNT: rd_byte = link1_count_q;
      `RDX_IDX_LINK2_COUNT: rd_byte = link2_count_q;
      `RDX_IDX_LINK3_COUNT: rd_byte = link3_count_q;
      default:              rd_byte = 8'h00;
    endcase
  end

  // Read data holds until the next read
  reg [31:0] rd_data_d;

  always @* begin
    rd_data_d = wb_dat_o;
    if (rd_stb) begin
      rd_data_d = {24'h000000, rd_byte};
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `RDX_RST_RDATA;
    end else if (ce) begin
      wb_ack_o <= ack_d;
      wb_dat_o <= rd_data_d;
    end
  end

endmodule
`default_nettype wire

/* test/rdx_checker.sv */
// Port checker for the receive data link extractor
`default_nettype none
`include "rdx_defs.vh"
module rdx_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        rx_bit_en,
  input wire logic        rx_data,
  input wire logic        rx_fbit,
  input wire logic [4:0]  rx_slot,
  input wire logic [2:0]  rx_bit_num,
  input wire logic        link1_bit,
  input wire logic        link1_valid,
  input wire logic        link2_bit,
  input wire logic        link2_valid,
  input wire logic        link3_bit,
  input wire logic        link3_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] ctl1_q;
  logic [7:0] ctl_q;
  logic [7:0] msk_q;
  logic       e1_q;
  wire        req  = ce && wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
  wire        take = rx_bit_en && ce;
  // Shadow of link 1 and link 2 control, link 2 mask and mode registers
  always @(posedge clk) begin
    if (!rst_n) begin
      ctl1_q <= 8'h20;
      ctl_q <= 8'h00;
      msk_q <= 8'h00;
      e1_q  <= 1'b0;
    end else if (req) begin
      if (wb_adr_i[7:2] == `RDX_IDX_LINK1_CTRL) ctl1_q <= wb_dat_i[7:0];
      if (wb_adr_i[7:2] == `RDX_IDX_LINK2_CTRL) ctl_q <= wb_dat_i[7:0];
      if (wb_adr_i[7:2] == `RDX_IDX_LINK2_MASK) msk_q <= wb_dat_i[7:0];
      if (wb_adr_i[7:2] == `RDX_IDX_MODE) e1_q <= wb_dat_i[0];
    end
  end
  a_sel_none: assert property (take && e1_q && !ctl1_q[7] && !ctl1_q[6] |=> !link1_valid)
    else $error("link1 bit with both selects clear");
  a_mask_off: assert property (take && !msk_q[3'h7 - rx_bit_num] |=> !link2_valid)
    else $error("link2 bit with mask clear");
  a_slot_e1: assert property (take && e1_q && rx_slot != ctl_q[4:0] |=> !link2_valid)
    else $error("link2 bit from other slot");
  a_slot_t1: assert property (take && !e1_q && rx_slot != ctl_q[4:0] + 5'h01 |=> !link2_valid)
    else $error("link2 bit from other channel");
  a_fbit_skip: assert property (take && rx_fbit |=> !link2_valid && !link3_valid)
    else $error("framing bit taken by slot link");
  a_hit_link2: assert property (take && ctl_q[7] && ctl_q[6] && !rx_fbit && msk_q[3'h7 - rx_bit_num]
    && rx_slot == (e1_q ? ctl_q[4:0] : ctl_q[4:0] + 5'h01) |=> link2_valid)
    else $error("link2 bit missed");
  a_link1_data: assert property (link1_valid |-> link1_bit == $past(rx_data))
    else $error("link1 bit differs from line");
  a_link3_data: assert property (link3_valid |-> $past(take) && link3_bit == $past(rx_data))
    else $error("link3 bit differs from line");
  a_idle_quiet: assert property (ce && !rx_bit_en |=> !link1_valid && !link2_valid && !link3_valid)
    else $error("link strobe without bit time");
  c_link1: cover property (link1_valid);
  c_link2: cover property (link2_valid);
  c_link3: cover property (link3_valid);
endmodule
bind rdx_top rdx_checker chk (.*);
`default_nettype wire

/* test/rdx_hdlc_model.sv */
// HDLC receiver input stage that collects extracted bits
`default_nettype none
module rdx_hdlc_model (
  input  wire logic       clk,
  input  wire logic       clr,
  input  wire logic       bit_i,
  input  wire logic       valid_i,
  output var  logic [7:0] shift_q,
  output var  logic [7:0] count_q
);
  timeunit 1ns;
  timeprecision 100ps;
  // Newest bit lands at bit 0
  always @(posedge clk) begin
    if (clr) begin
      shift_q <= 8'h00;
      count_q <= 8'h00;
    end else if (valid_i) begin
      shift_q <= {shift_q[6:0], bit_i};
      count_q <= count_q + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* test/rdx_tb_top.sv */
// Testbench for the receive data link extractor
`default_nettype none
module rdx_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 0, rst_n = 0, ce = 1, clr = 0;
  logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic        wb_ack_o, e1_mode;
  logic        rx_bit_en = 0, rx_data = 0, rx_fr_start = 0, rx_mf_start = 0, rx_fbit = 0, rx_fdl_pos = 0;
  logic [4:0]  rx_slot = 5'h00;
  logic [2:0]  rx_bit_num = 3'h0;
  logic        link1_bit, link1_valid, link2_bit, link2_valid, link3_bit, link3_valid;
  logic [7:0]  sh1, sh2, sh3, cn1, cn2, cn3, q;
  int          errors = 0, compares = 0;
  always #5 clk = ~clk;
  rdx_top dut (.*);
  rdx_hdlc_model m1 (.clk(clk), .clr(clr), .bit_i(link1_bit), .valid_i(link1_valid), .shift_q(sh1), .count_q(cn1));
  rdx_hdlc_model m2 (.clk(clk), .clr(clr), .bit_i(link2_bit), .valid_i(link2_valid), .shift_q(sh2), .count_q(cn2));
  rdx_hdlc_model m3 (.clk(clk), .clr(clr), .bit_i(link3_bit), .valid_i(link3_valid), .shift_q(sh3), .count_q(cn3));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] pat(input int s);
    return 8'(s) * 8'h25 ^ 8'hA5;
  endfunction
  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      give_verdict();
    end
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk("register", e, q);
  endtask
  task automatic frame(input logic mf, input logic e1, input logic fb);
    logic [7:0] p;
    @(posedge clk);
    rx_bit_en   <= 1'b1;
    rx_fr_start <= 1'b1;
    rx_mf_start <= mf;
    if (!e1) begin
      rx_fbit    <= 1'b1;
      rx_fdl_pos <= 1'b1;
      rx_data    <= fb;
      @(posedge clk);
      rx_fr_start <= 1'b0;
      rx_mf_start <= 1'b0;
    end
    for (int s = e1 ? 0 : 1; s <= (e1 ? 31 : 24); s++) begin
      for (int b = 0; b < 8; b++) begin
        p = pat(s);
        rx_fbit    <= 1'b0;
        rx_fdl_pos <= 1'b0;
        rx_slot    <= 5'(s);
        rx_bit_num <= 3'(b);
        rx_data    <= p[7 - b];
        @(posedge clk);
        rx_fr_start <= 1'b0;
        rx_mf_start <= 1'b0;
      end
    end
    rx_bit_en <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic restart();
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(8'hA0, 8'h20);
    for (int i = 1; i < 6; i++) rd(8'hA0 + 8'(4 * i), 8'h00);
    wb(1'b1, 8'hB4, 8'h5A);
    rd(8'hB4, 8'h5A);
    rd(8'hAC, 8'h00);
    rd(8'hC0, 8'h00);
    $display("register test done");
  endtask
  task automatic t_e1();
    logic [7:0] p;
    p = pat(31);
    wb(1'b1, 8'hB8, 8'h01);
    chk("e1 mode", 8'h01, {7'h0, e1_mode});
    wb(1'b1, 8'hA0, 8'h05);
    wb(1'b1, 8'hA4, 8'hFF);
    wb(1'b1, 8'hA8, 8'hC5);
    wb(1'b1, 8'hAC, 8'hFF);
    wb(1'b1, 8'hB0, 8'h5F);
    wb(1'b1, 8'hB4, 8'h81);
    restart();
    frame(1'b1, 1'b1, 1'b0);
    frame(1'b0, 1'b1, 1'b0);
    chk("link1 count", 8'h00, cn1);
    chk("link2 count", 8'h10, cn2);
    chk("link2 data", pat(5), sh2);
    chk("link3 count", 8'h02, cn3);
    chk("link3 data", {6'h00, p[7], p[0]}, sh3);
    rd(8'hBC, 8'h01);
    rd(8'hF0, 8'h00);
    rd(8'hF4, 8'h10);
    rd(8'hF8, 8'h02);
    $display("e1 test done");
  endtask
  task automatic t_t1();
    logic [7:0] p;
    p = pat(24);
    wb(1'b1, 8'hB8, 8'h00);
    wb(1'b1, 8'hA0, 8'h20);
    wb(1'b1, 8'hA8, 8'h41);
    wb(1'b1, 8'hAC, 8'h7F);
    wb(1'b1, 8'hB0, 8'h97);
    wb(1'b1, 8'hB4, 8'h01);
    restart();
    frame(1'b1, 1'b0, 1'b1);
    frame(1'b0, 1'b0, 1'b0);
    chk("link1 count", 8'h02, cn1);
    chk("link1 data", 8'h02, sh1);
    chk("link2 count", 8'h07, cn2);
    chk("link2 data", pat(2) & 8'h7F, sh2);
    chk("link3 count", 8'h01, cn3);
    chk("link3 data", {7'h00, p[0]}, sh3);
    rd(8'hBC, 8'h02);
    rd(8'hF0, 8'h02);
    rd(8'hF4, 8'h17);
    wb(1'b1, 8'hF4, 8'h00);
    rd(8'hF4, 8'h00);
    $display("t1 test done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_e1();
    t_t1();
    give_verdict();
  end
endmodule
`default_nettype wire
